// >>> design/gpmfc_power_seq.v
// Power mode sequencer with switch drive control and protection threshold selection
`timescale 1ns/1ps
`include "gpmfc_map.vh"

module gpmfc_power_seq (
  // Clock and reset
  input  wire        clock,
  input  wire        reset_n,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Analog and protector side
  input  wire [15:0] avgCurrentReading,
  input  wire        wakeCurrentDetect,
  input  wire        protChgFault,
  input  wire        protDsgFault,
  input  wire        hostCommActive,
  // Comm line stall, open drain
  input  wire        commLineIn,
  output reg         commLineOut,
  output reg         commLineOe,
  // Mode and control outputs
  output reg         hfOscEnable,
  output reg         measureStrobe,
  output reg         adcCalibrate,
  output reg         chargeSwitch,
  output reg         dischargeSwitch,
  output reg  [8:0]  ovThresholdMv,
  output reg  [4:0]  occThresholdMv
);

  localparam [1:0] MODE_FULL = 2'h0;
  localparam [1:0] MODE_CAL  = 2'h1;
  localparam [1:0] MODE_DOZE = 2'h2;
  localparam [1:0] MODE_DEEP = 2'h3;

  localparam integer STALL_ALL = `GPMFC_STALL_CYCLES;
  localparam [23:0]  STALL_MAX = STALL_ALL[23:0];

  // Synchronisers for pin inputs
  reg [1:0] wakeSync_r;
  reg [1:0] commSync_r;
  reg [1:0] lineSync_r;
  reg [1:0] chgFltSync_r;
  reg [1:0] dsgFltSync_r;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wakeSync_r   <= 2'h0;
      commSync_r   <= 2'h0;
      lineSync_r   <= 2'h3;
      chgFltSync_r <= 2'h0;
      dsgFltSync_r <= 2'h0;
    end else begin
      wakeSync_r   <= {wakeSync_r[0], wakeCurrentDetect};
      commSync_r   <= {commSync_r[0], hostCommActive};
      lineSync_r   <= {lineSync_r[0], commLineIn};
      chgFltSync_r <= {chgFltSync_r[0], protChgFault};
      dsgFltSync_r <= {dsgFltSync_r[0], protDsgFault};
    end
  end

  wire wakeDet  = wakeSync_r[1];
  wire commAct  = commSync_r[1] | ~lineSync_r[1];
  wire chgFault = chgFltSync_r[1];
  wire dsgFault = dsgFltSync_r[1];

  // Software registers
  reg        dozeEnable_r;
  reg        fwChgOff_r;
  reg        fwDsgOff_r;
  reg [15:0] dozeLevel_r;
  reg [15:0] delayCount_r;
  reg [2:0]  ovSel_r;
  reg [1:0]  occSel_r;
  reg        deepReq_r;
  reg        testMode_r;
  reg        testChg_r;
  reg        testDsg_r;
  reg [7:0]  nvm_r [0:63];

  // Sequencer state
  reg [1:0]  mode_r;
  reg [1:0]  mode_nxt;
  reg [7:0]  calCnt_r;
  reg [15:0] fsTimer_r;
  reg [23:0] tickCnt_r;
  reg [23:0] rateCnt_r;
  reg [7:0]  oscCnt_r;
  reg        stalling_r;
  reg [23:0] stallCnt_r;

  wire [15:0] avgCur   = avgCurrentReading;
  wire        belowLvl = avgCur < dozeLevel_r;
  wire        aboveLvl = avgCur > dozeLevel_r;
  wire        reqMeth  = deepReq_r && (delayCount_r == 16'h0000);
  wire        timeMeth = (delayCount_r != 16'h0000) && (fsTimer_r == 16'h0000);

  // Mode transitions
  always @* begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_FULL: begin
        if (dozeEnable_r && belowLvl && !wakeDet) begin
          mode_nxt = MODE_CAL;
        end
      end
      MODE_CAL: begin
        if (calCnt_r == `GPMFC_CAL_CYCLES) begin
          mode_nxt = MODE_DOZE;
        end
      end
      MODE_DOZE: begin
        if (aboveLvl || wakeDet || !dozeEnable_r) begin
          mode_nxt = MODE_FULL;
        end else if (reqMeth || timeMeth) begin
          mode_nxt = MODE_DEEP;
        end
      end
      MODE_DEEP: begin
        if (commAct || aboveLvl || wakeDet) begin
          mode_nxt = MODE_FULL;
        end
      end
      default: mode_nxt = MODE_FULL;
    endcase
  end

  // Bus access decode
  wire        busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        busWr  = busReq && wb_we_i && wb_sel_i[0];
  wire        nvmHit = wb_adr_i[7];
  wire [5:0]  nvmIdx = {wb_adr_i[6:2], 1'b0};

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_r     <= MODE_FULL;
      calCnt_r   <= 8'h00;
      fsTimer_r  <= 16'h0000;
      tickCnt_r  <= 24'h000000;
      rateCnt_r  <= 24'h000000;
      oscCnt_r   <= 8'h00;
      stalling_r <= 1'b0;
      stallCnt_r <= 24'h000000;
    end else begin
      mode_r <= mode_nxt;
      calCnt_r <= (mode_r == MODE_CAL) ? calCnt_r + 8'h01 : 8'h00;
      // Countdown loaded from the delay count on doze entry
      if (mode_r != MODE_DOZE) begin
        fsTimer_r <= delayCount_r;
        tickCnt_r <= 24'h000000;
      end else if (fsTimer_r != 16'h0000) begin
        if (tickCnt_r == `GPMFC_TICK_CYCLES - 24'd1) begin
          tickCnt_r <= 24'h000000;
          fsTimer_r <= fsTimer_r - 16'h0001;
        end else begin
          tickCnt_r <= tickCnt_r + 24'h000001;
        end
      end
      if (mode_r != mode_nxt || rateCnt_r == 24'h000000) begin
        case (mode_nxt)
          MODE_DOZE: rateCnt_r <= `GPMFC_RATE_DOZE;
          MODE_DEEP: rateCnt_r <= `GPMFC_RATE_DEEP;
          default:   rateCnt_r <= `GPMFC_RATE_FULL;
        endcase
      end else begin
        rateCnt_r <= rateCnt_r - 24'h000001;
      end
      // Oscillator restart time after leaving deep doze
      if (mode_r == MODE_DEEP) begin
        oscCnt_r <= `GPMFC_OSC_CYCLES;
      end else if (oscCnt_r != 8'h00) begin
        oscCnt_r <= oscCnt_r - 8'h01;
      end
      // Stall the line on a comm activity wake from deep doze until the oscillator is up
      if (mode_r == MODE_DEEP && commAct) begin
        stalling_r <= 1'b1;
        stallCnt_r <= 24'h000000;
      end else if (stalling_r) begin
        stallCnt_r <= stallCnt_r + 24'h000001;
        if (oscCnt_r == 8'h01 || stallCnt_r == STALL_MAX - 24'd2) begin
          stalling_r <= 1'b0;
        end
      end
    end
  end

  // Registers written by software
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dozeEnable_r <= 1'b0;
      fwChgOff_r   <= 1'b0;
      fwDsgOff_r   <= 1'b0;
      dozeLevel_r  <= 16'h0000;
      delayCount_r <= 16'h0000;
      ovSel_r      <= `GPMFC_OV_RESET;
      occSel_r     <= `GPMFC_OCC_RESET;
      deepReq_r    <= 1'b0;
      testMode_r   <= 1'b0;
      testChg_r    <= 1'b0;
      testDsg_r    <= 1'b0;
    end else begin
      // A comm activity wake from deep doze clears the request even during a bus write; a request written now wins
      if (mode_r == MODE_DEEP && commAct) begin
        deepReq_r <= 1'b0;
      end
      if (busWr && wb_adr_i == `GPMFC_CTRL_ADDR) begin
        dozeEnable_r <= wb_dat_i[`GPMFC_CTRL_DOZE_EN];
        fwChgOff_r   <= wb_dat_i[`GPMFC_CTRL_FW_CHG];
        fwDsgOff_r   <= wb_dat_i[`GPMFC_CTRL_FW_DSG];
      end else if (busWr && wb_adr_i == `GPMFC_DOZECUR_ADDR && wb_sel_i[1]) begin
        dozeLevel_r <= wb_dat_i[15:0];
      end else if (busWr && wb_adr_i == `GPMFC_DELAY_ADDR && wb_sel_i[1]) begin
        delayCount_r <= wb_dat_i[15:0];
      end else if (busWr && wb_adr_i == `GPMFC_PROTCFG_ADDR) begin
        ovSel_r  <= wb_dat_i[`GPMFC_OV_LSB+2:`GPMFC_OV_LSB];
        occSel_r <= wb_dat_i[`GPMFC_OCC_LSB+1:`GPMFC_OCC_LSB];
      end else if (busWr && wb_adr_i == `GPMFC_CMD_ADDR) begin
        if (wb_dat_i[7:0] == `GPMFC_CMD_DEEPDOZE) begin
          deepReq_r <= 1'b1;
        end else if (wb_dat_i[7:0] == `GPMFC_CMD_SWTEST_LO) begin
          testMode_r <= 1'b1;
          testChg_r  <= wb_dat_i[8];
          testDsg_r  <= wb_dat_i[9];
        end else if (wb_dat_i[7:0] == `GPMFC_CMD_SWTEST_HI) begin
          testMode_r <= 1'b0;
        end
      end
    end
  end

  // User storage: two 32-byte blocks, two bytes per word
  genvar gi;
  generate
    for (gi = 0; gi < 64; gi = gi + 1) begin : gNvm
      always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          nvm_r[gi] <= 8'hff;
        end else if (busReq && wb_we_i && nvmHit && {26'h0, nvmIdx} == gi - gi % 2) begin
          if (gi % 2 == 0 && wb_sel_i[0]) begin
            nvm_r[gi] <= wb_dat_i[7:0];
          end else if (gi % 2 == 1 && wb_sel_i[1]) begin
            nvm_r[gi] <= wb_dat_i[15:8];
          end
        end
      end
    end
  endgenerate

  // Threshold lookup
  reg [8:0] ovLut;
  reg [4:0] occLut;
  always @* begin
    ovLut = 9'd275 + {1'b0, ovSel_r, 5'h00} - {3'h0, ovSel_r, 3'h0} + {6'h00, ovSel_r};
    case (occSel_r)
      2'h0: occLut = 5'd6;
      2'h1: occLut = 5'd13;
      2'h2: occLut = 5'd18;
      default: occLut = 5'd28;
    endcase
  end

  // Read mux
  reg [31:0] rdData;
  always @* begin
    rdData = 32'h00000000;
    if (nvmHit) begin
      rdData = {16'h0000, nvm_r[nvmIdx + 6'd1], nvm_r[nvmIdx]};
    end else if (wb_adr_i == `GPMFC_CTRL_ADDR) begin
      rdData = {29'h0, fwDsgOff_r, fwChgOff_r, dozeEnable_r};
    end else if (wb_adr_i == `GPMFC_DOZECUR_ADDR) begin
      rdData = {16'h0000, dozeLevel_r};
    end else if (wb_adr_i == `GPMFC_DELAY_ADDR) begin
      rdData = {16'h0000, delayCount_r};
    end else if (wb_adr_i == `GPMFC_PROTCFG_ADDR) begin
      rdData = {26'h0, occSel_r, 1'b0, ovSel_r};
    end else if (wb_adr_i == `GPMFC_STATUS_ADDR) begin
      rdData = {16'h0, fsTimer_r[7:0], stalling_r, testMode_r, deepReq_r,
                dsgFault, chgFault, hfOscEnable, mode_r};
    end else if (wb_adr_i == `GPMFC_AVGCUR_ADDR) begin
      rdData = {16'h0000, avgCur};
    end else if (wb_adr_i == `GPMFC_SWTEST_ADDR) begin
      rdData = {29'h0, testDsg_r, testChg_r, testMode_r};
    end else if (wb_adr_i == `GPMFC_THRESH_ADDR) begin
      rdData = {11'h0, occLut, 7'h0, ovLut};
    end
  end

  // Registered outputs
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o        <= 1'b0;
      wb_dat_o        <= 32'h00000000;
      commLineOut     <= 1'b0;
      commLineOe      <= 1'b0;
      hfOscEnable     <= 1'b1;
      measureStrobe   <= 1'b0;
      adcCalibrate    <= 1'b0;
      chargeSwitch    <= 1'b0;
      dischargeSwitch <= 1'b0;
      ovThresholdMv   <= 9'd450;
      occThresholdMv  <= 5'd18;
    end else begin
      wb_ack_o        <= busReq;
      wb_dat_o        <= busReq ? rdData : 32'h00000000;
      commLineOut     <= 1'b0;
      commLineOe      <= stalling_r;
      hfOscEnable     <= (mode_nxt != MODE_DEEP);
      measureStrobe   <= (rateCnt_r == 24'h000000) && (mode_r != MODE_CAL);
      adcCalibrate    <= (mode_nxt == MODE_CAL);
      // Protector fault has final authority; test mode cannot override it
      chargeSwitch    <= !chgFault && (testMode_r ? testChg_r : !fwChgOff_r);
      dischargeSwitch <= !dsgFault && (testMode_r ? testDsg_r : !fwDsgOff_r);
      ovThresholdMv   <= ovLut;
      occThresholdMv  <= occLut;
    end
  end

endmodule

// >>> design/gpmfc_map.vh
// Register offsets, field positions, reset values and timing counts of the power mode sequencer
`ifndef GPMFC_MAP_VH
`define GPMFC_MAP_VH

// Word offsets (byte addresses) of the Wishbone registers
`define GPMFC_CTRL_ADDR      8'h00
`define GPMFC_DOZECUR_ADDR   8'h04
`define GPMFC_DELAY_ADDR     8'h08
`define GPMFC_PROTCFG_ADDR   8'h0c
`define GPMFC_STATUS_ADDR    8'h10
`define GPMFC_AVGCUR_ADDR    8'h14
`define GPMFC_SWTEST_ADDR    8'h18
`define GPMFC_THRESH_ADDR    8'h1c
`define GPMFC_CMD_ADDR       8'h20
`define GPMFC_NVM_ADDR       8'h80

// Control register fields
`define GPMFC_CTRL_DOZE_EN   0
`define GPMFC_CTRL_FW_CHG    1
`define GPMFC_CTRL_FW_DSG    2

// Protection configuration fields
`define GPMFC_OV_LSB         0
`define GPMFC_OCC_LSB        4
`define GPMFC_OV_RESET       3'h7
`define GPMFC_OCC_RESET      2'h2

// Command codes: switch test entry and exit, and deep doze request
`define GPMFC_CMD_SWTEST_LO  8'h74
`define GPMFC_CMD_SWTEST_HI  8'h75
`define GPMFC_CMD_DEEPDOZE   8'h13

// Measurement rates: one less than the cycles between measurement strobes per mode
`define GPMFC_RATE_FULL      24'd50
`define GPMFC_RATE_DOZE      24'd400
`define GPMFC_RATE_DEEP      24'd3200

// Calibration length, oscillator restart and stall limit
`define GPMFC_CAL_CYCLES     8'd16
`define GPMFC_OSC_CYCLES     8'd32
`define GPMFC_STALL_NS       4000000
`define GPMFC_CLK_NS         20
`define GPMFC_STALL_CYCLES   (`GPMFC_STALL_NS / `GPMFC_CLK_NS)

// Deep doze delay counter prescale: cycles per count
`define GPMFC_TICK_CYCLES    24'd1000

`endif

// >>> bench/gpmfc_power_seq_asserts.sv
// Port checks of the power mode sequencer
`timescale 1ns/1ps
module gpmfc_power_seq_asserts (
  // Clock and reset
  input wire        clock,
  input wire        reset_n,
  // Bus
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  // Causes
  input wire        protChgFault,
  input wire        protDsgFault,
  input wire        hostCommActive,
  // Effects
  input wire        commLineOut,
  input wire        commLineOe,
  input wire        hfOscEnable,
  input wire        adcCalibrate,
  input wire        chargeSwitch,
  input wire        dischargeSwitch,
  input wire [8:0]  ovThresholdMv,
  input wire [4:0]  occThresholdMv
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // A fault must pass two sync flops before it bites
  sequence chgHeld;
    protChgFault [*3];
  endsequence
  sequence dsgHeld;
    protDsgFault [*3];
  endsequence
  sequence calRun;
    adcCalibrate [*8];
  endsequence
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_chg_fault: assert property (chgHeld |=> !chargeSwitch)
    else $error("charge switch on in fault");
  chk_dsg_fault: assert property (dsgHeld |=> !dischargeSwitch)
    else $error("discharge switch on in fault");
  chk_cal_run: assert property ($rose(adcCalibrate) |-> calRun ##1 calRun
    ##1 adcCalibrate ##1 !adcCalibrate) else $error("calibration length wrong");
  chk_ov_table: assert property (ovThresholdMv >= 275 && ovThresholdMv <= 450
    && (ovThresholdMv - 275) % 25 == 0) else $error("overvoltage threshold off table");
  chk_occ_table: assert property (occThresholdMv inside {6, 13, 18, 28})
    else $error("charge overcurrent threshold off table");
  chk_line_drive: assert property (commLineOe |-> !commLineOut)
    else $error("line driven high");
  chk_stall_free: assert property ($rose(commLineOe) |-> ##[1:64] !commLineOe)
    else $error("stall not released");
  chk_deep_wake: assert property (!hfOscEnable && hostCommActive |-> ##[1:6] hfOscEnable)
    else $error("no wake on activity");
endmodule

// >>> bench/gpmfc_host_model.sv
// Host side of the serial line: pulls it low on request, waits out device stalls
`timescale 1ns/1ps
module gpmfc_host_model (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // Bench request
  input  wire logic poke,
  // Device side of the line
  input  wire logic devOe,
  input  wire logic devOut,
  output logic      lineLevel,
  output logic      commActive
);
  logic [2:0] lowCnt_r = 3'h0;
  logic       pending_r = 1'b0;
  // Pulled up line, low while either party pulls
  assign lineLevel = !((devOe && !devOut) || lowCnt_r != 3'h0);
  assign commActive = lowCnt_r != 3'h0;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lowCnt_r <= 3'h0;
      pending_r <= 1'b0;
    end else if (pending_r && lowCnt_r == 3'h0 && !(devOe && !devOut)) begin
      lowCnt_r <= 3'h4;
      pending_r <= 1'b0;
    end else begin
      pending_r <= pending_r | poke;
      lowCnt_r <= lowCnt_r - {2'h0, lowCnt_r != 3'h0};
    end
  end
endmodule

// >>> bench/gpmfc_power_seq_tb.sv
// Register level bench of the power mode sequencer
`timescale 1ns/1ps
`include "gpmfc_map.vh"
module gpmfc_power_seq_tb;
  logic        clock = 0;
  logic        reset_n = 0;
  logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [7:0]  wb_adr_i = 0;
  logic [3:0]  wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q;
  logic [15:0] avgCurrentReading = 0;
  logic        wakeCurrentDetect = 0, protChgFault = 0, protDsgFault = 0, hostPoke = 0;
  logic        hostCommActive, commLineIn, commLineOut, commLineOe, hfOscEnable;
  logic        measureStrobe, adcCalibrate, chargeSwitch, dischargeSwitch;
  logic [8:0]  ovThresholdMv;
  logic [4:0]  occThresholdMv;
  int          n_errors = 0, check_count = 0, i;
  int          occTab[4] = '{6, 13, 18, 28};
  always #10 clock = ~clock;
  gpmfc_power_seq i_dut (.clock, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .avgCurrentReading, .wakeCurrentDetect,
    .protChgFault, .protDsgFault, .hostCommActive, .commLineIn, .commLineOut, .commLineOe,
    .hfOscEnable, .measureStrobe, .adcCalibrate, .chargeSwitch, .dischargeSwitch,
    .ovThresholdMv, .occThresholdMv);
  gpmfc_host_model i_host (.clock, .reset_n, .poke(hostPoke), .devOe(commLineOe),
    .devOut(commLineOut), .lineLevel(commLineIn), .commActive(hostCommActive));
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task tally_and_finish;
    if (n_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clock);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    check("ack", wb_ack_o, 1);
    if (wb_ack_o !== 1'b1)
      tally_and_finish;
  endtask
  task waitMode(input logic [1:0] m);
    int k;
    k = 0;
    do begin
      wb(0, `GPMFC_STATUS_ADDR, 0, 4'hf);
      k++;
    end while (q[1:0] !== m && k < 3000);
    check("mode", q[1:0], m);
    if (q[1:0] !== m)
      tally_and_finish;
  endtask
  task sw(input string name, input logic [1:0] exp);
    repeat (5) @(posedge clock);
    check(name, {dischargeSwitch, chargeSwitch}, exp);
  endtask
  // Cycles from one measurement strobe to the next
  task gap(input string name, input logic [31:0] exp);
    int k;
    repeat (2) begin
      k = 0;
      do begin
        @(posedge clock);
        k++;
      end while (measureStrobe !== 1'b1 && k < 4000);
    end
    check(name, k, exp);
    if (k >= 4000)
      tally_and_finish;
  endtask
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1;
    @(posedge clock);
    check("ovReset", ovThresholdMv, 450);
    check("occReset", occThresholdMv, 18);
    gap("fullRate", `GPMFC_RATE_FULL + 24'd1);
    wb(1, 8'h40, 32'h1234, 4'hf);
    wb(0, 8'h40, 0, 4'hf);
    check("unmapped", q, 0);
    // Low byte only, then the second block apart from the first
    wb(1, `GPMFC_NVM_ADDR, 32'h5aa5, 4'h1);
    wb(1, 8'hc0, 32'h3c, 4'h3);
    wb(0, `GPMFC_NVM_ADDR, 0, 4'hf);
    check("nvmA", q & 32'hffff, 32'hffa5);
    wb(0, 8'hc0, 0, 4'hf);
    check("nvmB", q & 32'hffff, 32'h3c);
    for (i = 0; i < 8; i++) begin
      wb(1, `GPMFC_PROTCFG_ADDR, (i % 4) << 4 | i, 4'hf);
      repeat (2) @(posedge clock);
      check("ovSel", ovThresholdMv, 275 + 25 * i);
      check("occSel", occThresholdMv, occTab[i % 4]);
    end
    for (i = 0; i < 2; i++) begin
      {protDsgFault, protChgFault} <= 2'(1 << i);
      sw("faultOff", 2'(~(1 << i)));
      {protDsgFault, protChgFault} <= 0;
      sw("faultClear", 3);
    end
    wb(1, `GPMFC_CTRL_ADDR, 6, 4'hf);
    sw("fwOff", 0);
    wb(1, `GPMFC_CTRL_ADDR, 0, 4'hf);
    sw("fwClear", 3);
    for (i = 0; i < 4; i++) begin
      wb(1, `GPMFC_CMD_ADDR, `GPMFC_CMD_SWTEST_LO | i << 8, 4'hf);
      sw("swTest", 2'(i));
    end
    wb(1, `GPMFC_CMD_ADDR, `GPMFC_CMD_SWTEST_HI, 4'hf);
    sw("swTestEnd", 3);
    avgCurrentReading <= 16'd10;
    wb(1, `GPMFC_DOZECUR_ADDR, 100, 4'hf);
    wb(1, `GPMFC_CTRL_ADDR, 1, 4'hf);
    waitMode(1);
    waitMode(2);
    wakeCurrentDetect <= 1;
    waitMode(0);
    wakeCurrentDetect <= 0;
    waitMode(2);
    wb(1, `GPMFC_CMD_ADDR, `GPMFC_CMD_DEEPDOZE, 4'hf);
    waitMode(3);
    check("oscOff", hfOscEnable, 0);
    wb(1, `GPMFC_CTRL_ADDR, 0, 4'hf);
    wb(0, `GPMFC_STATUS_ADDR, 0, 4'hf);
    check("deepHold", q[1:0], 3);
    gap("deepRate", `GPMFC_RATE_DEEP + 24'd1);
    hostPoke <= 1;
    @(posedge clock);
    hostPoke <= 0;
    waitMode(0);
    check("oscOn", hfOscEnable, 1);
    wb(1, `GPMFC_CTRL_ADDR, 1, 4'hf);
    waitMode(2);
    repeat (300) @(posedge clock);
    wb(0, `GPMFC_STATUS_ADDR, 0, 4'hf);
    check("dozeHold", q[1:0], 2);
    gap("dozeRate", `GPMFC_RATE_DOZE + 24'd1);
    avgCurrentReading <= 16'd200;
    waitMode(0);
    wb(1, `GPMFC_DELAY_ADDR, 2, 4'hf);
    avgCurrentReading <= 16'd10;
    waitMode(2);
    wb(0, `GPMFC_STATUS_ADDR, 0, 4'hf);
    check("timerRun", q[1:0], 2);
    waitMode(3);
    tally_and_finish;
  end
endmodule
bind gpmfc_power_seq gpmfc_power_seq_asserts i_chk (.clock, .reset_n, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .protChgFault, .protDsgFault, .hostCommActive, .commLineOut, .commLineOe,
  .hfOscEnable, .adcCalibrate, .chargeSwitch, .dischargeSwitch, .ovThresholdMv,
  .occThresholdMv);
